//--- hdl/phy_regbank_pkg.sv
// Constants, field layout and carrier types for the paged PHY register bank
// Operation
// - Accel enable set drives ACK-accelerated and fly-by arbitration enhancements.
// - Accel and multispeed enables clear on hardware reset, survive bus reset.
// - In 1394b mode both enables have no effect on behaviour.
// - Multispeed enable permits concatenated packets of differing speeds.
// - Read-only legacy speed holds max self-ID legacy speed, capped at S400.
// - Read-only beta link bit reflects the beta link select pin.
// - Two-bit writable bridge field feeds self-ID packets, resets to zero.
// - Three-bit page choice selects page at 8..15; hardware reset only.
// - Four-bit port choice selects port from zero; hardware reset only.
// - Unimplemented selected port makes whole status page read as zero.
// - Line/link register: tpa, tpb, downstream, link, receive ok, port off.
// - Sleep register: reserved low bits, sleep, permit, loop, standby, forced off.
// - Line state codes: 11 high impedance, 01 one, 10 zero, 00 invalid.
package phy_regbank_pkg;

   // Bus geometry
   localparam int APB_ADDR_W = 8;
   localparam int DATA_W     = 32;
   localparam int REG_W      = 8;
   localparam int IDX_W      = 4;
   localparam int PORTS_DEF  = 3;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_FEATURE      = 4'h5;
   localparam logic [IDX_W-1:0] IDX_LEGACY       = 4'h6;
   localparam logic [IDX_W-1:0] IDX_PAGE_PORT    = 4'h7;
   localparam logic [IDX_W-1:0] IDX_PORT_LINE    = 4'h8;
   localparam logic [IDX_W-1:0] IDX_PORT_SPEED   = 4'h9;
   localparam logic [IDX_W-1:0] IDX_PORT_CAP     = 4'hA;
   localparam logic [IDX_W-1:0] IDX_PORT_RELIAB  = 4'hB;
   localparam logic [IDX_W-1:0] IDX_PORT_ERRCNT  = 4'hC;
   localparam logic [IDX_W-1:0] IDX_PORT_SLEEP   = 4'hD;
   localparam logic [IDX_W-1:0] IDX_PORT_RSVD_A  = 4'hE;
   localparam logic [IDX_W-1:0] IDX_PORT_RSVD_B  = 4'hF;
   localparam logic [IDX_W-1:0] IDX_FIRST_MAPPED = IDX_FEATURE;

   // Feature register fields
   localparam int FEAT_MULTI_BIT = 0;
   localparam int FEAT_ACCEL_BIT = 1;

   // Legacy speed / beta link / bridge register fields
   localparam int LEG_SPEED_LSB  = 0;
   localparam int BETA_LINK_BIT  = 3;
   localparam int BRIDGE_LSB     = 4;

   // Page and port selector fields
   localparam int PORT_SEL_LSB   = 0;
   localparam int PAGE_SEL_LSB   = 5;
   localparam logic [2:0] PAGE_PORT_STATUS = 3'h0;

   // Line and link state register fields
   localparam int LINE_TPA_LSB   = 0;
   localparam int LINE_TPB_LSB   = 2;
   localparam int LINE_DOWN_BIT  = 4;
   localparam int LINE_LINK_BIT  = 5;
   localparam int LINE_RECEIVE_OK_FLAG_BIT  = 6;
   localparam int LINE_OFF_BIT   = 7;

   // Speed and event control register fields
   localparam int SPD_RATE_LSB   = 0;
   localparam int SPD_IRQEN_BIT  = 3;
   localparam int SPD_SRERR_BIT  = 4;
   localparam int SPD_SBERR_BIT  = 5;
   localparam int SPD_SCRM_BIT   = 6;
   localparam int SPD_BONLY_BIT  = 7;

   // Sleep and standby register fields
   localparam int SLP_IND_BIT    = 3;
   localparam int SLP_PERMIT_BIT = 4;
   localparam int SLP_LOOP_BIT   = 5;
   localparam int SLP_STBY_BIT   = 6;
   localparam int SLP_FORCED_BIT = 7;

   // Speed code cap and line state codes
   localparam logic [2:0] SPEED_S100  = 3'h0;
   localparam logic [2:0] SPEED_S400  = 3'h2;
   localparam logic [1:0] LINE_Z       = 2'h3;
   localparam logic [1:0] LINE_ONE     = 2'h1;
   localparam logic [1:0] LINE_ZERO    = 2'h2;
   localparam logic [1:0] LINE_INVALID = 2'h0;

   // Reset values
   localparam logic [REG_W-1:0]  REG_ZERO  = 8'h00;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

   // Per-port status from the port state machines
   typedef struct packed {
      logic [1:0]       tpa_line_state;
      logic [1:0]       tpb_line_state;
      logic             downstream_port_flag;
      logic             link_attached_flag;
      logic             receive_ok_flag;
      logic [2:0]       negotiated_rate;
      logic [REG_W-1:0] speed_capability;
      logic [REG_W-1:0] reliability;
      logic [REG_W-1:0] error_count;
      logic             sleep_indicator;
      logic             standby_active;
      logic             suspend_resume_event;
      logic             standby_error_event;
      logic             standby_exit;
   } port_status_s;

   // Per-port controls held by the register bank
   typedef struct packed {
      logic port_off_control;
      logic port_event_irq_enable;
      logic suspend_resume_error;
      logic standby_error_flag;
      logic scrambler_off;
      logic sleep_permit;
      logic loop_block;
      logic forced_port_off;
   } port_ctrl_s;

   localparam port_ctrl_s CTRL_RESET = '0;

endpackage

//--- hdl/port_status_slice.sv
// Per-port status page registers for one cable port
`timescale 1ns/100ps
module port_status_slice
   import phy_regbank_pkg::*;
(
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   // Register access
   input  wire logic             i_wr_en,
   input  wire logic [IDX_W-1:0] i_idx,
   input  wire logic [REG_W-1:0] i_wr_data,
   output logic      [REG_W-1:0] o_rd_data,
   // Port side
   input  wire port_status_s     i_status,
   output port_ctrl_s            o_ctrl
);

   port_ctrl_s ctrl;
   port_ctrl_s next_ctrl;

   // Software writes first, hardware events after so a set wins over a clear
   always_comb
   begin
      next_ctrl = ctrl;
      if (i_wr_en)
      begin
         unique case (i_idx)
            IDX_PORT_LINE:
            begin
               next_ctrl.port_off_control = i_wr_data[LINE_OFF_BIT];
            end
            IDX_PORT_SPEED:
            begin
               next_ctrl.port_event_irq_enable = i_wr_data[SPD_IRQEN_BIT];
               next_ctrl.scrambler_off         = i_wr_data[SPD_SCRM_BIT];
               // Error flags clear on a written one
               if (i_wr_data[SPD_SRERR_BIT])
               begin
                  next_ctrl.suspend_resume_error = 1'b0;
               end
               if (i_wr_data[SPD_SBERR_BIT])
               begin
                  next_ctrl.standby_error_flag = 1'b0;
               end
            end
            IDX_PORT_SLEEP:
            begin
               next_ctrl.sleep_permit    = i_wr_data[SLP_PERMIT_BIT];
               next_ctrl.loop_block      = i_wr_data[SLP_LOOP_BIT];
               next_ctrl.forced_port_off = i_wr_data[SLP_FORCED_BIT];
            end
            default:
            begin
               next_ctrl = ctrl; // Read-only and reserved words ignore writes
            end
         endcase
      end
      if (i_status.standby_exit)
      begin
         next_ctrl.standby_error_flag = 1'b0;
      end
      if (i_status.suspend_resume_event)
      begin
         next_ctrl.suspend_resume_error = 1'b1;
      end
      if (i_status.standby_error_event)
      begin
         next_ctrl.standby_error_flag = 1'b1;
      end
   end

   // Control state register
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctrl <= CTRL_RESET;
      end
      else
      begin
         ctrl <= next_ctrl;
      end
   end

   assign o_ctrl = ctrl;

   // Read word assembly
   always_comb
   begin
      o_rd_data = REG_ZERO;
      unique case (i_idx)
         IDX_PORT_LINE:
         begin
            o_rd_data[LINE_TPA_LSB +: 2] = i_status.tpa_line_state;
            o_rd_data[LINE_TPB_LSB +: 2] = i_status.tpb_line_state;
            o_rd_data[LINE_DOWN_BIT]     = i_status.downstream_port_flag;
            o_rd_data[LINE_LINK_BIT]     = i_status.link_attached_flag;
            o_rd_data[LINE_RECEIVE_OK_FLAG_BIT]     = i_status.receive_ok_flag;
            o_rd_data[LINE_OFF_BIT]      = ctrl.port_off_control;
         end
         IDX_PORT_SPEED:
         begin
            o_rd_data[SPD_RATE_LSB +: 3] = i_status.negotiated_rate;
            o_rd_data[SPD_IRQEN_BIT]     = ctrl.port_event_irq_enable;
            o_rd_data[SPD_SRERR_BIT]     = ctrl.suspend_resume_error;
            o_rd_data[SPD_SBERR_BIT]     = ctrl.standby_error_flag;
            o_rd_data[SPD_SCRM_BIT]      = ctrl.scrambler_off;
            o_rd_data[SPD_BONLY_BIT]     = 1'b0; // Beta-only never set here
         end
         IDX_PORT_CAP:    o_rd_data = i_status.speed_capability;
         IDX_PORT_RELIAB: o_rd_data = i_status.reliability;
         IDX_PORT_ERRCNT: o_rd_data = i_status.error_count;
         IDX_PORT_SLEEP:
         begin
            o_rd_data[SLP_IND_BIT]    = i_status.sleep_indicator;
            o_rd_data[SLP_PERMIT_BIT] = ctrl.sleep_permit;
            o_rd_data[SLP_LOOP_BIT]   = ctrl.loop_block;
            o_rd_data[SLP_STBY_BIT]   = i_status.standby_active;
            o_rd_data[SLP_FORCED_BIT] = ctrl.forced_port_off;
         end
         default:
         begin
            o_rd_data = REG_ZERO;
         end
      endcase
   end

endmodule

//--- hdl/phy_paged_register_bank.sv
// APB register bank with base controls and paged per-port status
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module phy_paged_register_bank
   import phy_regbank_pkg::*;
#(
   parameter int NUM_PORTS = PORTS_DEF
)
(
   // Clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst_n,
   // APB slave
   input  wire logic                    i_psel,
   input  wire logic                    i_penable,
   input  wire logic                    i_pwrite,
   input  wire logic [APB_ADDR_W-1:0]   i_paddr,
   input  wire logic [DATA_W-1:0]       i_pwdata,
   output logic      [DATA_W-1:0]       o_prdata,
   output logic                         o_pready,
   output logic                         o_pslverr,
   // PHY core status
   input  wire logic                    i_beta_mode_op,
   input  wire logic                    i_beta_link_select_pin,
   input  wire logic                    i_bus_reset,
   input  wire logic                    i_selfid_speed_valid,
   input  wire logic [2:0]              i_selfid_speed,
   input  wire port_status_s [NUM_PORTS-1:0] i_port_status,
   // PHY core controls
   output port_ctrl_s [NUM_PORTS-1:0]   o_port_ctrl,
   output logic                         o_accel_arb_active,
   output logic                         o_multispeed_concat_active,
   output logic      [1:0]              o_bridge_field
);

   // Base register state
   logic                accel_arb_enable;
   logic                multispeed_concat_enable;
   logic [2:0]          legacy_path_speed_max;
   logic [1:0]          bridge;
   logic [2:0]          register_page_choice;
   logic [3:0]          port_choice;
   logic [DATA_W-1:0]   prdata;
   logic                next_accel_arb_enable;
   logic                next_multispeed_concat_enable;
   logic [2:0]          next_legacy_path_speed_max;
   logic [1:0]          next_bridge;
   logic [2:0]          next_register_page_choice;
   logic [3:0]          next_port_choice;
   logic [DATA_W-1:0]   next_prdata;

   // Pin synchroniser
   logic                beta_pin_meta;
   logic                beta_link_present;

   // Decode
   logic [IDX_W-1:0]    idx;
   logic                mapped;
   logic                wr_access;
   logic                port_page;
   logic                port_valid;
   logic [2:0]          capped_speed;
   logic [REG_W-1:0]    base_word;
   logic [REG_W-1:0]    page_word;
   logic [REG_W-1:0]    port_rd [NUM_PORTS];

   // Word index and map check; upper address bits must be zero
   assign idx        = i_paddr[2 +: IDX_W];
   assign mapped     = (i_paddr[APB_ADDR_W-1:IDX_W+2] == '0) && (idx >= IDX_FIRST_MAPPED);
   assign wr_access  = i_psel && i_penable && i_pwrite && mapped;
   // Port page reached only with page zero selected
   assign port_page  = (idx >= IDX_PORT_LINE) && (register_page_choice == PAGE_PORT_STATUS);
   assign port_valid = ({28'h0000000, port_choice} < NUM_PORTS);

   // Zero-wait slave: access phase always completes
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;
   assign o_prdata  = prdata;

   // Pin crosses in through two flops before use
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         beta_pin_meta     <= 1'b0;
         beta_link_present <= 1'b0;
      end
      else
      begin
         beta_pin_meta     <= i_beta_link_select_pin;
         beta_link_present <= beta_pin_meta;
      end
   end

   // Enables only take effect outside 1394b mode
   assign o_accel_arb_active         = accel_arb_enable && !i_beta_mode_op;
   assign o_multispeed_concat_active = multispeed_concat_enable && !i_beta_mode_op;
   assign o_bridge_field             = bridge;

   // Self-ID speed clipped to the legacy ceiling
   assign capped_speed = (i_selfid_speed > SPEED_S400) ? SPEED_S400 : i_selfid_speed;

   // Base register next values
   always_comb
   begin
      next_accel_arb_enable         = accel_arb_enable;
      next_multispeed_concat_enable = multispeed_concat_enable;
      next_legacy_path_speed_max    = legacy_path_speed_max;
      next_bridge                   = bridge;
      next_register_page_choice     = register_page_choice;
      next_port_choice              = port_choice;
      // Bus reset restarts the legacy scan only; enables and selectors hold
      if (i_bus_reset)
      begin
         next_legacy_path_speed_max = SPEED_S100;
      end
      else if (i_selfid_speed_valid && (capped_speed > legacy_path_speed_max))
      begin
         next_legacy_path_speed_max = capped_speed;
      end
      if (wr_access)
      begin
         unique case (idx)
            IDX_FEATURE:
            begin
               next_accel_arb_enable         = i_pwdata[FEAT_ACCEL_BIT];
               next_multispeed_concat_enable = i_pwdata[FEAT_MULTI_BIT];
            end
            IDX_LEGACY:
            begin
               next_bridge = i_pwdata[BRIDGE_LSB +: 2];
            end
            IDX_PAGE_PORT:
            begin
               next_register_page_choice = i_pwdata[PAGE_SEL_LSB +: 3];
               next_port_choice          = i_pwdata[PORT_SEL_LSB +: 4];
            end
            default:
            begin
               next_bridge = bridge; // Paged words handled by the port slices
            end
         endcase
      end
   end

   // Base read word
   always_comb
   begin
      base_word = REG_ZERO;
      unique case (idx)
         IDX_FEATURE:
         begin
            base_word[FEAT_ACCEL_BIT] = accel_arb_enable;
            base_word[FEAT_MULTI_BIT] = multispeed_concat_enable;
         end
         IDX_LEGACY:
         begin
            base_word[LEG_SPEED_LSB +: 3] = legacy_path_speed_max;
            base_word[BETA_LINK_BIT]      = beta_link_present;
            base_word[BRIDGE_LSB +: 2]    = bridge;
         end
         IDX_PAGE_PORT:
         begin
            base_word[PAGE_SEL_LSB +: 3] = register_page_choice;
            base_word[PORT_SEL_LSB +: 4] = port_choice;
         end
         default:
         begin
            base_word = REG_ZERO;
         end
      endcase
   end

   // Paged read word; absent ports and other pages read as zero
   always_comb
   begin
      page_word = REG_ZERO;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         if (port_valid && (port_choice == p[3:0]))
         begin
            page_word = port_rd[p];
         end
      end
   end

   // Read data captured in the setup phase so it stands through access
   always_comb
   begin
      next_prdata = prdata;
      if (i_psel && !i_penable)
      begin
         next_prdata = WORD_ZERO;
         if (mapped && (idx >= IDX_PORT_LINE))
         begin
            next_prdata[REG_W-1:0] = port_page ? page_word : REG_ZERO;
         end
         else if (mapped)
         begin
            next_prdata[REG_W-1:0] = base_word;
         end
      end
   end

   // Base register state; hardware reset clears all
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         accel_arb_enable         <= 1'b0;
         multispeed_concat_enable <= 1'b0;
         legacy_path_speed_max    <= SPEED_S100;
         bridge                   <= 2'h0;
         register_page_choice     <= PAGE_PORT_STATUS;
         port_choice              <= 4'h0;
         prdata                   <= WORD_ZERO;
      end
      else
      begin
         accel_arb_enable         <= next_accel_arb_enable;
         multispeed_concat_enable <= next_multispeed_concat_enable;
         legacy_path_speed_max    <= next_legacy_path_speed_max;
         bridge                   <= next_bridge;
         register_page_choice     <= next_register_page_choice;
         port_choice              <= next_port_choice;
         prdata                   <= next_prdata;
      end
   end

   // One status slice per implemented port
   for (genvar g = 0; g < NUM_PORTS; g++)
   begin : g_port
      logic slice_wr;
      // Only the selected port on page zero sees a write
      assign slice_wr = wr_access && port_page && (port_choice == 4'(g));
      port_status_slice u_slice
      (
         .i_ref_clk (i_ref_clk),
         .i_rst_n   (i_rst_n),
         .i_wr_en   (slice_wr),
         .i_idx     (idx),
         .i_wr_data (i_pwdata[REG_W-1:0]),
         .o_rd_data (port_rd[g]),
         .i_status  (i_port_status[g]),
         .o_ctrl    (o_port_ctrl[g])
      );
   end

endmodule

//--- dv/phy_regbank_chk.sv
// Assertion checker for the paged PHY register bank
`timescale 1ns/100ps
module phy_regbank_chk
   import phy_regbank_pkg::*;
(
   // Watched top-level ports
   input wire logic                  i_ref_clk,
   input wire logic                  i_rst_n,
   input wire logic                  i_psel,
   input wire logic                  i_penable,
   input wire logic                  i_pwrite,
   input wire logic [APB_ADDR_W-1:0] i_paddr,
   input wire logic [DATA_W-1:0]     i_pwdata,
   input wire logic [DATA_W-1:0]     o_prdata,
   input wire logic                  o_pready,
   input wire logic                  o_pslverr,
   input wire logic                  i_beta_mode_op,
   input wire logic                  i_bus_reset,
   input wire logic                  o_accel_arb_active,
   input wire logic                  o_multispeed_concat_active,
   input wire logic [1:0]            o_bridge_field
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   // Access phase and write qualifiers
   logic acc;
   logic wr;
   assign acc = i_psel && i_penable;
   assign wr  = acc && i_pwrite;

   // Zero wait states, so a stuck-low ready would hang software
   a_ready_high: assert property (acc |-> o_pready) else $error("ready low in access");
   a_beta_gates: assert property (
      i_beta_mode_op |-> !o_accel_arb_active && !o_multispeed_concat_active) else $error("enable active in beta");
   a_accel_write: assert property (
      wr && i_paddr == 8'h14 |=> o_accel_arb_active == ($past(i_pwdata[1]) && !i_beta_mode_op))
      else $error("accel enable not taken");
   a_multi_write: assert property (
      wr && i_paddr == 8'h14 |=> o_multispeed_concat_active == ($past(i_pwdata[0]) && !i_beta_mode_op))
      else $error("multispeed enable not taken");
   a_enables_kept: assert property (
      i_bus_reset && !wr && !i_beta_mode_op ##1 !i_beta_mode_op
      |-> $stable(o_accel_arb_active) && $stable(o_multispeed_concat_active)) else $error("enable lost");
   a_bridge_write: assert property (
      wr && i_paddr == 8'h18 |=> o_bridge_field == $past(i_pwdata[5:4])) else $error("bridge not taken");
   a_error_map: assert property (
      acc |-> o_pslverr == (i_paddr[7:6] != 2'h0 || i_paddr[5:2] < IDX_FIRST_MAPPED)) else $error("bad pslverr");
   a_upper_zero: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0) else $error("upper read bits");
   a_rsvd_zero: assert property (
      acc && !i_pwrite && i_paddr[7:3] == 5'h07 |-> o_prdata == WORD_ZERO) else $error("reserved not zero");

   // Main scenarios reached
   c_accel_set: cover property (wr && i_paddr == 8'h14 && i_pwdata[1]);
   c_unmapped: cover property (acc && o_pslverr);
   c_bus_reset: cover property (i_bus_reset ##1 o_accel_arb_active);
endmodule

bind phy_paged_register_bank phy_regbank_chk u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_beta_mode_op(i_beta_mode_op), .i_bus_reset(i_bus_reset), .o_accel_arb_active(o_accel_arb_active),
   .o_multispeed_concat_active(o_multispeed_concat_active), .o_bridge_field(o_bridge_field));

//--- dv/llc_apb_master.sv
// Link controller model: APB master reaching the register bank
`timescale 1ns/100ps
module llc_apb_master
   import phy_regbank_pkg::*;
(
   // Clock
   input  wire logic                  i_ref_clk,
   // APB request and answer
   output logic                       o_psel,
   output logic                       o_penable,
   output logic                       o_pwrite,
   output logic      [APB_ADDR_W-1:0] o_paddr,
   output logic      [DATA_W-1:0]     o_pwdata,
   input  wire logic                  i_pready,
   // Wait bound used up
   output logic                       o_timeout
);
   // Idle bus at time zero
   initial
   begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 8'h00;
      o_pwdata  = 32'h0;
      o_timeout = 1'b0;
   end

   // One transfer held until ready is sampled or 16 cycles have passed
   task automatic xfer(input logic w, input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      o_psel   <= 1'b1;
      o_pwrite <= w;
      o_paddr  <= {2'h0, idx, 2'h0};
      o_pwdata <= {24'($urandom()), d};
      @(posedge i_ref_clk);
      o_penable <= 1'b1;
      do
      begin
         @(posedge i_ref_clk);
         n++;
      end
      while (i_pready !== 1'b1 && n < 16);
      o_timeout <= (i_pready !== 1'b1);
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      // Released lines must not keep the last value
      o_paddr   <= ~o_paddr;
      o_pwdata  <= ~o_pwdata;
   endtask
endmodule

//--- dv/phy_paged_register_bank_tb.sv
// Self-checking bench for the paged PHY register bank
`timescale 1ns/100ps
module phy_paged_register_bank_tb;
   import phy_regbank_pkg::*;
   localparam int NP = 3;
   // Design connections and bench state
   logic                  ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, tmo;
   logic                  beta_mode, beta_pin, bus_reset, sid_valid, accel, multi;
   logic [2:0]            sid_speed;
   logic [1:0]            bridge;
   logic [APB_ADDR_W-1:0] paddr;
   logic [DATA_W-1:0]     pwdata, prdata;
   port_status_s [NP-1:0] pstat;
   port_ctrl_s [NP-1:0]   pctrl;
   logic [33:0]           expq[$];
   logic [33:0]           e;
   int                    n_fail, tests_run;

   // Clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   phy_paged_register_bank #(.NUM_PORTS(NP)) dut (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_beta_mode_op(beta_mode), .i_beta_link_select_pin(beta_pin), .i_bus_reset(bus_reset),
      .i_selfid_speed_valid(sid_valid), .i_selfid_speed(sid_speed), .i_port_status(pstat),
      .o_port_ctrl(pctrl), .o_accel_arb_active(accel), .o_multispeed_concat_active(multi),
      .o_bridge_field(bridge));

   llc_apb_master llc (
      .i_ref_clk(ref_clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
      .o_pwdata(pwdata), .i_pready(pready), .o_timeout(tmo));

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Note the expected answer, then run the transfer
   task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d, input logic err);
      expq.push_back({w, err, 24'h0, d});
      llc.xfer(w, idx, d);
   endtask

   // One-cycle pulses on the status side
   task automatic sid(input logic [2:0] s);
      @(posedge ref_clk);
      sid_valid <= 1'b1;
      sid_speed <= s;
      @(posedge ref_clk);
      sid_valid <= 1'b0;
   endtask

   task automatic bus_rst();
      @(posedge ref_clk);
      bus_reset <= 1'b1;
      @(posedge ref_clk);
      bus_reset <= 1'b0;
   endtask

   function automatic logic [7:0] line_exp(int p);
      if (p >= NP)
         return 8'h00;
      return {1'b0, pstat[p].receive_ok_flag, pstat[p].link_attached_flag, pstat[p].downstream_port_flag,
              pstat[p].tpb_line_state, pstat[p].tpa_line_state};
   endfunction

   // Compare each completed transfer with the oldest note
   always @(posedge ref_clk)
   begin
      if (psel && penable && pready)
      begin
         e = expq.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]});
         if (!e[33])
            check(prdata, e[31:0]);
      end
      if (tmo)
      begin
         n_fail++;
         conclude();
      end
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h5E86));
      {rst_n, beta_mode, beta_pin, bus_reset, sid_valid, sid_speed} = '0;
      pstat = (NP*$bits(port_status_s))'({$urandom(), $urandom(), $urandom(), $urandom()});
      // Line codes spread so all four appear
      for (int i = 0; i < NP; i++)
      begin
         pstat[i].tpa_line_state = 2'(i);
         pstat[i].tpb_line_state = 2'(i + 1);
         {pstat[i].suspend_resume_event, pstat[i].standby_error_event, pstat[i].standby_exit} = 3'h0;
      end
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      xfer(0, 4'h5, 8'h00, 0);
      xfer(0, 4'h6, 8'h00, 0);
      xfer(0, 4'h7, 8'h00, 0);
      xfer(1, 4'h2, 8'hFF, 1);
      xfer(0, 4'h4, 8'h00, 1);
      xfer(1, 4'h5, 8'h03, 0);
      @(negedge ref_clk);
      check({30'h0, accel, multi}, 32'h3);
      @(posedge ref_clk);
      beta_mode <= 1'b1;
      @(negedge ref_clk);
      check({30'h0, accel, multi}, 32'h0);
      @(posedge ref_clk);
      beta_mode <= 1'b0;
      bus_rst();
      xfer(0, 4'h5, 8'h03, 0);
      // Legacy speed tracks the maximum, capped
      sid(3'h1);
      sid(3'h5);
      xfer(0, 4'h6, 8'h02, 0);
      bus_rst();
      xfer(0, 4'h6, 8'h00, 0);
      @(posedge ref_clk);
      beta_pin <= 1'b1;
      xfer(1, 4'h6, 8'h37, 0);
      xfer(0, 4'h6, 8'h38, 0);
      check({30'h0, bridge}, 32'h3);
      // Walk the port selector past the last port
      for (int p = 0; p < 5; p++)
      begin
         xfer(1, 4'h7, 8'(p), 0);
         xfer(0, 4'h7, 8'(p), 0);
         xfer(0, 4'h8, line_exp(p), 0);
         xfer(0, 4'hC, p < NP ? pstat[p].error_count : 8'h00, 0);
      end
      xfer(1, 4'h7, 8'h01, 0);
      xfer(1, 4'h8, 8'hFF, 0);
      @(negedge ref_clk);
      check({29'h0, pctrl[2].port_off_control, pctrl[1].port_off_control, pctrl[0].port_off_control}, 32'h2);
      xfer(0, 4'h8, line_exp(1) | 8'h80, 0);
      xfer(1, 4'h7, 8'h00, 0);
      xfer(1, 4'hD, 8'hFF, 0);
      xfer(0, 4'hD, {1'b1, pstat[0].standby_active, 2'h3, pstat[0].sleep_indicator, 3'h0}, 0);
      xfer(1, 4'h9, 8'hC8, 0);
      @(posedge ref_clk);
      pstat[0].suspend_resume_event <= 1'b1;
      @(posedge ref_clk);
      pstat[0].suspend_resume_event <= 1'b0;
      xfer(0, 4'h9, {4'h5, 1'b1, pstat[0].negotiated_rate}, 0);
      xfer(1, 4'h9, 8'h10, 0);
      xfer(0, 4'h9, {5'h00, pstat[0].negotiated_rate}, 0);
      xfer(1, 4'h7, 8'h20, 0);
      xfer(0, 4'h8, 8'h00, 0);
      xfer(1, 4'hE, 8'hFF, 0);
      xfer(0, 4'hE, 8'h00, 0);
      xfer(0, 4'hF, 8'h00, 0);
      // Second hardware reset mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      xfer(0, 4'h5, 8'h00, 0);
      xfer(0, 4'h7, 8'h00, 0);
      xfer(0, 4'h6, 8'h08, 0);
      // Let the monitor take the last answer first
      repeat (2) @(posedge ref_clk);
      conclude();
   end
endmodule
